/* File: core/sfp_flash_seq.v */
`timescale 1ns/1ns
`default_nettype none
`include "sfp_flash_regs.vh"

module sfp_flash_seq (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire [3:0]  sio_in,
  output reg  [3:0]  sio_out,
  output reg  [3:0]  sio_oe,
  input  wire        quad_cmd_mode,
  input  wire        quad_io_enable_bit,
  input  wire        protection_scheme_select,
  input  wire [3:0]  region_lock_bits,
  input  wire        otp_locked,
  input  wire        erase_done,
  input  wire        soft_reset_done,
  input  wire [7:0]  array_rdata,
  output reg  [23:0] prog_addr,
  output reg  [7:0]  prog_data,
  output reg         prog_we,
  output reg         prog_otp,
  output reg         write_latch_bit,
  output reg         op_in_progress_bit,
  output reg  [7:0]  factory_state_byte,
  output wire        deep_sleep,
  output reg         otp_mode,
  output reg         suspend_req
);

  localparam [1:0] PW_ON    = 2'h0;
  localparam [1:0] PW_ENTER = 2'h1;
  localparam [1:0] PW_SLEEP = 2'h2;
  localparam [1:0] PW_WAKE  = 2'h3;

  // counts worked out as integers, then cut to the counter width on purpose
  localparam integer PP_N   = `SFP_PP_CYC;
  localparam integer DP_N   = `SFP_DP_CYC;
  localparam integer RES_N  = `SFP_RES_CYC;
  localparam [10:0] PP_CYC  = PP_N[10:0];
  localparam [10:0] DP_CYC  = DP_N[10:0];
  localparam [10:0] RES_CYC = RES_N[10:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage 0 is read only by stage 1

  reg [2:0]   cs_s;
  reg [2:0]   ck_s;
  reg [3:0]   d_a;
  reg [3:0]   d_b;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      d_a  <= 4'h0;
      d_b  <= 4'h0;
    end else begin
      cs_s <= {cs_s[1:0], cs_n};
      ck_s <= {ck_s[1:0], sclk};
      d_a  <= sio_in;
      d_b  <= d_a;
    end
  end

  wire cs_fall = cs_s[2] & ~cs_s[1];
  wire cs_rise = ~cs_s[2] & cs_s[1];
  wire ck_rise = ~ck_s[2] & ck_s[1] & ~cs_s[1];
  wire ck_fall = ck_s[2] & ~ck_s[1] & ~cs_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // frame shifter

  reg [7:0]   sh;
  reg [2:0]   bitcnt;
  reg [2:0]   bcnt;
  reg [7:0]   opc;
  reg [23:0]  addr;
  reg [7:0]   col;
  reg         got_data;
  reg [255:0] vld;
  reg         rd_on;
  reg [7:0]   out_sh;
  reg [1:0]   pw;
  reg [10:0]  st;
  reg         prun;
  reg [10:0]  pt;
  reg [15:0]  pbase;

  wire       wide  = quad_cmd_mode | ((bcnt != 3'h0) && (opc == `SFP_OP_QPAGE));
  wire [7:0] sh_nx = wide ? {sh[3:0], d_b} : {sh[6:0], d_b[0]};
  wire [2:0] bit_nx = bitcnt + (wide ? 3'h4 : 3'h1);
  wire       byte_done = ck_rise && (bit_nx == 3'h0);
  wire       act = (pw == PW_ON) && !op_in_progress_bit;
  wire       clean = (bitcnt == 3'h0);
  wire       bare = clean && (bcnt == 3'h1);
  wire       data_wr = byte_done && (bcnt == `SFP_DATA_PHASE) && act;

  // top blocks locked, more of them for higher codes
  wire [3:0] nprot = (region_lock_bits >= `SFP_LOCK_ALL) ? `SFP_BLOCKS :
                     (4'h1 << (region_lock_bits - 4'h1));
  wire       locked = !otp_mode && !protection_scheme_select && (region_lock_bits != 4'h0)
                      && ({1'b0, addr[18:16]} >= (`SFP_BLOCKS - nprot));
  wire       page_op = (opc == `SFP_OP_PAGE) ||
                       ((opc == `SFP_OP_QPAGE) && quad_io_enable_bit);
  wire       prog_ok = act && clean && (bcnt == `SFP_DATA_PHASE) && got_data
                       && write_latch_bit && page_op && !locked
                       && !(otp_mode && otp_locked);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sh       <= 8'h00;
      bitcnt   <= 3'h0;
      bcnt     <= 3'h0;
      opc      <= 8'h00;
      addr     <= 24'h000000;
      col      <= 8'h00;
      got_data <= 1'b0;
    end else if (cs_fall) begin
      bitcnt   <= 3'h0;
      bcnt     <= 3'h0;
      got_data <= 1'b0;
    end else if (ck_rise) begin
      sh     <= sh_nx;
      bitcnt <= bit_nx;
      if (byte_done) begin
        if (bcnt != `SFP_DATA_PHASE) begin
          bcnt <= bcnt + 3'h1;
        end
        if (bcnt == 3'h0) begin
          opc <= sh_nx;
        end else if (bcnt <= `SFP_ADDR_BYTES) begin
          addr <= {addr[15:0], sh_nx};
          if (bcnt == `SFP_ADDR_BYTES) begin
            col <= sh_nx;
          end
        end else begin
          got_data <= 1'b1;
          col      <= col + 8'h01;
        end
      end
    end
  end

  // later bytes overwrite earlier ones at the same column
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      vld <= 256'h0;
    end else if (cs_fall && !op_in_progress_bit) begin
      vld <= 256'h0;
    end else if (data_wr) begin
      vld[col] <= 1'b1;
    end
  end

  wire [7:0] m_rdata;

  sfp_page_mem u_page (
    .clk   (ref_clk),
    .we    (data_wr),
    .waddr (col),
    .wdata (sh_nx),
    .raddr (pt[8:1]),
    .rdata (m_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // factory state read output, shifted on falling sclk

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_on   <= 1'b0;
      out_sh  <= 8'h00;
      sio_out <= 4'h0;
      sio_oe  <= 4'h0;
    end else if (cs_s[1]) begin
      rd_on  <= 1'b0;
      sio_oe <= 4'h0;
    end else if (byte_done && (bcnt == 3'h0) && (sh_nx == `SFP_OP_FACT_RD) && act) begin
      rd_on  <= 1'b1;
      out_sh <= factory_state_byte;
    end else if (ck_fall && rd_on) begin
      // byte repeats for as long as the host keeps clocking
      if (quad_cmd_mode) begin
        sio_out <= out_sh[7:4];
        sio_oe  <= 4'hf;
        out_sh  <= {out_sh[3:0], out_sh[7:4]};
      end else begin
        sio_out <= {2'h0, out_sh[7], 1'b0};
        sio_oe  <= 4'h2;
        out_sh  <= {out_sh[6:0], out_sh[7]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution at deselect

  wire prog_end = prun && (pt == PP_CYC - 11'h001);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      write_latch_bit    <= 1'b0;
      op_in_progress_bit <= 1'b0;
      factory_state_byte <= `SFP_FACT_RST;
      otp_mode           <= 1'b0;
      suspend_req        <= 1'b0;
      prun               <= 1'b0;
      pbase              <= 16'h0000;
      prog_otp           <= 1'b0;
    end else begin
      suspend_req <= 1'b0;
      if (prog_end) begin
        op_in_progress_bit <= 1'b0;
        write_latch_bit    <= 1'b0;
        prun               <= 1'b0;
      end
      if (prog_end || erase_done || soft_reset_done) begin
        factory_state_byte <= `SFP_FACT_OFF;
      end
      if (cs_rise) begin
        if (prog_ok) begin
          op_in_progress_bit <= 1'b1;
          prun               <= 1'b1;
          pbase              <= addr[23:8];
          prog_otp           <= otp_mode;
        end
        if (bare && act) begin
          if (opc == `SFP_OP_LATCH_SET && !(otp_mode && otp_locked)) begin
            write_latch_bit <= 1'b1;
          end
          if (opc == `SFP_OP_FACT_EN && !(otp_mode && otp_locked)) begin
            factory_state_byte <= `SFP_FACT_ON;
          end
          if (opc == `SFP_OP_OTP_IN) begin
            otp_mode <= 1'b1;
          end
          if (opc == `SFP_OP_OTP_OUT) begin
            otp_mode <= 1'b0;
          end
        end
        // suspend aimed at a running engine, so busy does not block it
        if (bare && (pw == PW_ON) && (opc == `SFP_OP_SUSPEND)
            && (factory_state_byte == `SFP_FACT_OFF)) begin
          suspend_req <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program engine: two cycles per column, then wait out the cycle time

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pt        <= 11'h000;
      prog_addr <= 24'h000000;
      prog_data <= 8'h00;
      prog_we   <= 1'b0;
    end else if (!prun) begin
      pt      <= 11'h000;
      prog_we <= 1'b0;
    end else begin
      pt <= pt + 11'h001;
      if (pt[10:9] != 2'h0) begin
        prog_we <= 1'b0;
      end else if (!pt[0]) begin
        prog_addr <= {pbase, pt[8:1]};
        prog_we   <= 1'b0;
      end else begin
        prog_data <= m_rdata & array_rdata;
        prog_we   <= vld[pt[8:1]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // deep power-down

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pw <= PW_ON;
      st <= 11'h000;
    end else begin
      case (pw)
        PW_ON: begin
          st <= 11'h000;
          if (cs_rise && bare && act && (opc == `SFP_OP_SLEEP)) begin
            pw <= PW_ENTER;
          end
        end
        PW_ENTER: begin
          st <= st + 11'h001;
          if (st == DP_CYC - 11'h001) begin
            pw <= PW_SLEEP;
          end
        end
        PW_SLEEP: begin
          st <= 11'h000;
          // everything but a clean wake is ignored here
          if (cs_rise && bare && (opc == `SFP_OP_WAKE)) begin
            pw <= PW_WAKE;
          end
        end
        default: begin
          st <= st + 11'h001;
          if (st == RES_CYC - 11'h001) begin
            pw <= PW_ON;
          end
        end
      endcase
    end
  end

  assign deep_sleep = (pw == PW_SLEEP);

endmodule

`default_nettype wire

/* File: core/sfp_flash_regs.vh */
`ifndef SFP_FLASH_REGS_VH
`define SFP_FLASH_REGS_VH

// command codes
`define SFP_OP_LATCH_SET   8'h06
`define SFP_OP_PAGE        8'h02
`define SFP_OP_QPAGE       8'h38
`define SFP_OP_FACT_EN     8'h41
`define SFP_OP_FACT_RD     8'h44
`define SFP_OP_SLEEP       8'hb9
`define SFP_OP_WAKE        8'hab
`define SFP_OP_OTP_IN      8'hb1
`define SFP_OP_OTP_OUT     8'hc1
`define SFP_OP_SUSPEND     8'hb0

// factory state byte
`define SFP_FACT_OFF       8'h00
`define SFP_FACT_ON        8'hff
`define SFP_FACT_RST       8'h00

// frame layout: opcode byte, three address bytes, then data
`define SFP_ADDR_BYTES     3'h3
`define SFP_DATA_PHASE     3'h4
`define SFP_PAGE_LAST      8'hff

// region lock: eight 64 KB blocks, full lock from this code upward
`define SFP_LOCK_ALL       4'h4
`define SFP_BLOCKS         4'h8

// timing
`define SFP_CLK_MHZ        100
`define SFP_T_PP_NS        10000
`define SFP_T_DP_NS        10000
`define SFP_T_RES_NS       10000
`define SFP_PP_CYC         ((`SFP_T_PP_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_DP_CYC         ((`SFP_T_DP_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_RES_CYC        ((`SFP_T_RES_NS * `SFP_CLK_MHZ) / 1000)

`endif

/* File: core/sfp_page_mem.v */
`timescale 1ns/1ns
`default_nettype none

module sfp_page_mem (
  input  wire       clk,
  input  wire       we,
  input  wire [7:0] waddr,
  input  wire [7:0] wdata,
  input  wire [7:0] raddr,
  output reg  [7:0] rdata
);

  reg [7:0] mem [0:255];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

/* File: tb/sfp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_host_model (
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] sio
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sio  = 4'h0;
  end
  // only the cs_n fall is skewed by 3 ns; sel still takes 80 ns, so sclk edges keep the caller's timing
  task automatic sel();
    #3 cs_n = 1'b0;
    #77;
  endtask
  // n bits on line 0, or n nibbles on four lines, msb first
  task automatic put(input logic [7:0] b, input int n, input bit q);
    for (int i = 0; i < n; i++) begin
      sio = q ? (i[0] ? b[3:0] : b[7:4]) : {3'h0, b[7-i]};
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
  // released lines show the inverse, never the last value
  task automatic desel();
    #80 cs_n = 1'b1;
    sio = ~sio;
    #157;
  endtask
endmodule
`default_nettype wire

/* File: tb/sfp_flash_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module sfp_flash_asserts (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        prog_we,
  input wire logic [23:0] prog_addr,
  input wire logic        write_latch_bit,
  input wire logic        op_in_progress_bit,
  input wire logic [7:0]  factory_state_byte,
  input wire logic        deep_sleep,
  input wire logic        otp_mode,
  input wire logic        suspend_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_we_busy: assert property (prog_we |-> op_in_progress_bit)
    else $error("write while idle");
  chk_start_latch: assert property ($rose(op_in_progress_bit) |-> write_latch_bit)
    else $error("start without latch");
  chk_end_clear: assert property ($fell(op_in_progress_bit) |-> !write_latch_bit
    && factory_state_byte == 8'h00) else $error("flags kept");
  chk_fact_code: assert property (factory_state_byte inside {8'h00, 8'hff})
    else $error("bad factory byte");
  chk_susp_fact: assert property (suspend_req |-> factory_state_byte != 8'hff)
    else $error("suspend in factory");
  chk_page_fixed: assert property (prog_we && $past(prog_we, 2) |->
    prog_addr[23:8] == $past(prog_addr[23:8], 2)) else $error("page moved");
  chk_sleep_hold: assert property (deep_sleep && $past(deep_sleep) |->
    $stable(write_latch_bit) && $stable(otp_mode)) else $error("command in sleep");
  chk_otp_cs: assert property ($changed(otp_mode) |-> cs_n && $past(cs_n, 2))
    else $error("otp change in frame");
endmodule
bind sfp_flash_seq sfp_flash_asserts u_chk (.*);
`default_nettype wire

/* File: tb/tb_sfp_flash_seq.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sfp_flash_regs.vh"
module tb_sfp_flash_seq;
  logic        ref_clk;
  logic        sys_rst;
  logic        quad_io_enable_bit;
  logic        protection_scheme_select;
  logic [3:0]  region_lock_bits;
  logic [7:0]  array_rdata;
  logic        otp_locked;
  logic        erase_done;
  logic [7:0]  rb;
  wire  [3:0]  sio_out;
  wire  [3:0]  sio_oe;
  wire         prog_otp;
  wire         cs_n;
  wire         sclk;
  wire  [3:0]  sio;
  wire  [23:0] prog_addr;
  wire  [7:0]  prog_data;
  wire  [7:0]  factory_state_byte;
  wire         prog_we;
  wire         write_latch_bit;
  wire         op_in_progress_bit;
  wire         deep_sleep;
  wire         otp_mode;
  wire         suspend_req;
  logic [31:0] expq[$];
  logic [7:0]  col[256];
  int          fails;
  int          compares;
  int          nsusp;
  sfp_host_model host (.cs_n(cs_n), .sclk(sclk), .sio(sio));
  sfp_flash_seq dut (.*, .sio_in(sio), .quad_cmd_mode(1'b0), .soft_reset_done(1'b0));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cmd(input logic [7:0] op);
    host.sel();
    host.put(op, 8, 0);
    host.desel();
  endtask
  // later bytes overwrite earlier ones in the same column
  task automatic pw(input logic [7:0] op, input logic [23:0] a, input int nb, input bit q);
    logic [7:0] d;
    host.sel();
    host.put(op, 8, 0);
    for (int i = 0; i < 3; i++) host.put(a[23-8*i -: 8], q ? 2 : 8, q);
    for (int k = 0; k < nb; k++) begin
      d = 8'($urandom);
      col[(a[7:0] + k) % 256] = d;
      host.put(d, q ? 2 : 8, q);
    end
  endtask
  task automatic exp_page(input logic [23:0] a, input int nb);
    for (int c = 0; c < 256; c++)
      if (nb >= 256 || ((c - a[7:0] + 256) % 256) < nb)
        expq.push_back({a[23:8], 8'(c), col[c] & array_rdata});
  endtask
  // factory state read: opcode, then eight clocks sampled on sclk rise
  task automatic fread(output logic [7:0] d);
    host.sel();
    host.put(`SFP_OP_FACT_RD, 8, 0);
    fork
      host.put(8'h00, 8, 0);
      repeat (8) begin
        @(posedge sclk);
        d = {d[6:0], sio_out[1]};
      end
    join
    chk(sio_oe, 4'h2);
    host.desel();
  endtask
  // bounded a little past the 1000-cycle program time
  task automatic idle();
    for (int n = 0; op_in_progress_bit !== 1'b0; n++) begin
      cyc(1);
      if (n > 1200) begin
        fails++;
        close_out();
      end
    end
  endtask
  always @(negedge ref_clk) begin
    if (suspend_req === 1'b1) nsusp++;
    if (prog_we === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else chk({prog_addr, prog_data}, expq.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h0989));
    sys_rst = 1'b1;
    quad_io_enable_bit = 1'b0;
    protection_scheme_select = 1'b0;
    region_lock_bits = 4'h0;
    array_rdata = 8'hff;
    otp_locked = 1'b0;
    erase_done = 1'b0;
    cyc(12);
    sys_rst = 1'b0;
    cyc(4);
    chk(factory_state_byte, 8'h00);
    fread(rb);
    chk(rb, 8'h00);
    pw(`SFP_OP_PAGE, 24'h000100, 1, 0);
    host.desel();
    cyc(20);
    chk(op_in_progress_bit, 1'b0);
    cmd(`SFP_OP_LATCH_SET);
    cmd(`SFP_OP_FACT_EN);
    chk(factory_state_byte, 8'hff);
    array_rdata = 8'($urandom);
    pw(`SFP_OP_PAGE, 24'h0123fe, 258, 0);
    exp_page(24'h0123fe, 258);
    host.desel();
    cyc(20);
    chk(op_in_progress_bit, 1'b1);
    idle();
    chk({write_latch_bit, factory_state_byte}, 9'h000);
    chk(expq.size(), 0);
    cmd(`SFP_OP_LATCH_SET);
    pw(`SFP_OP_PAGE, 24'h000200, 1, 0);
    host.put(8'ha5, 3, 0);
    host.desel();
    cyc(20);
    chk({op_in_progress_bit, write_latch_bit}, 2'b01);
    // quad enable off, top block locked, then allowed
    for (int t = 0; t < 3; t++) begin
      quad_io_enable_bit = (t != 0);
      region_lock_bits = (t == 1) ? 4'h1 : 4'h0;
      cmd(`SFP_OP_LATCH_SET);
      pw(`SFP_OP_QPAGE, 24'h07ff10, 2, 1);
      if (t == 2) exp_page(24'h07ff10, 2);
      host.desel();
      cyc(20);
      chk(op_in_progress_bit, t == 2);
      idle();
    end
    cmd(`SFP_OP_SLEEP);
    cyc(900);
    chk(deep_sleep, 1'b0);
    cyc(200);
    chk(deep_sleep, 1'b1);
    cmd(`SFP_OP_LATCH_SET);
    chk(write_latch_bit, 1'b0);
    cmd(`SFP_OP_WAKE);
    chk(deep_sleep, 1'b0);
    cyc(1010);
    cmd(`SFP_OP_LATCH_SET);
    chk(write_latch_bit, 1'b1);
    cmd(`SFP_OP_OTP_IN);
    chk(otp_mode, 1'b1);
    pw(`SFP_OP_PAGE, 24'h000040, 1, 0);
    exp_page(24'h000040, 1);
    host.desel();
    cyc(20);
    chk(prog_otp, 1'b1);
    idle();
    otp_locked = 1'b1;
    cmd(`SFP_OP_LATCH_SET);
    chk(write_latch_bit, 1'b0);
    cmd(`SFP_OP_FACT_EN);
    chk(factory_state_byte, 8'h00);
    cmd(`SFP_OP_OTP_OUT);
    chk(otp_mode, 1'b0);
    otp_locked = 1'b0;
    cmd(`SFP_OP_SUSPEND);
    cmd(`SFP_OP_FACT_EN);
    cmd(`SFP_OP_SUSPEND);
    chk(nsusp, 1);
    fread(rb);
    chk(rb, 8'hff);
    // second reset in mid-run must drop factory mode
    cyc(1);
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(4);
    chk(factory_state_byte, 8'h00);
    cmd(`SFP_OP_FACT_EN);
    chk(factory_state_byte, 8'hff);
    cyc(1);
    erase_done = 1'b1;
    cyc(1);
    erase_done = 1'b0;
    cyc(2);
    chk(factory_state_byte, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
